// *** rtl/quadrature_pos_rev_counter_pkg.sv ***
// Package of register offsets, field layouts and modes for the quadrature position counter
// Notes on behaviour
// - Max position is reload data on wrap
// - Modes 00/10/11: overflow sets flag, clears position
// - Mode 01: overflow sets flag, keeps counting
// - Mode 10: wrap to zero, revolution up, flag
// - Underflow reloads max, revolution down in modes 10/11, flag
// - Direction comes only from phase inputs
// - Mask only in modes 00 and 11
// - Index, overflow, underflow load mask counter
// - Same-direction counts decrement mask; nonzero suppresses
// - Direction reversal forces mask counter zero
// - Mask zero: index clears position; overflow clears it whatever the mask
// - Mode or direction change releases mask
// - Masked wraps keep revolution, still flag
// - Setting 10 masks index two counts
// - Setting 00 disables masking entirely
// - Position readable live, writable only stopped
// - Position clears on reset, index, overflow wrap; write loads it
// - Index function select: clear or gate
package quadrature_pos_rev_counter_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] POS_OFS  = 8'h00; // position_count_value
  localparam logic [7:0] REV_OFS  = 8'h04; // revolution_count_value
  localparam logic [7:0] MAX_OFS  = 8'h08; // max_position_reload
  localparam logic [7:0] CTRL_OFS = 8'h0c; // control bits
  localparam logic [7:0] FLAG_OFS = 8'h10; // irq_control_flags_low

  // ****************************************************************
  // Control and flag field positions
  // ****************************************************************
  localparam int PCM_LSB  = 0;  // Position mode, 2 bits
  localparam int RCM_LSB  = 2;  // revolution_mode_sel, 2 bits
  localparam int POSITION_STOP_BIT_BIT = 4;  // position_stop_bit
  localparam int INDEX_FUNCTION_SEL_BIT = 5;  // index_function_sel
  localparam int SWAP_BIT = 7;  // Swap phase inputs
  localparam int CGE_LSB  = 8;  // index_edge_sel, 2 bits
  localparam int RESET_MASK_SETTING_LSB = 10; // reset_mask_setting, 2 bits
  localparam int OVERFLOW_FLAG_BIT = 0;  // overflow_flag
  localparam int UNDERFLOW_FLAG_BIT = 1;  // underflow_flag
  localparam int DIR_BIT  = 2;  // Last direction, read only

  // ****************************************************************
  // Reset values and constants
  // ****************************************************************
  localparam logic [15:0] POS_RST  = 16'h0000;
  localparam logic [15:0] REV_RST  = 16'h0000;
  localparam logic [15:0] MAX_RST  = 16'hffff;
  localparam logic [11:0] CTRL_RST = 12'h010; // Stopped after reset
  localparam logic [1:0]  MASK_OFF = 2'h0;
  localparam logic [1:0]  AXI_OKAY = 2'h0;
  localparam logic [1:0]  AXI_SLVERR = 2'h2;

  // Revolution modes
  typedef enum logic [1:0] {
    revolution_disabled_mode       = 2'b00,
    revolution_index_only_mode     = 2'b01,
    revolution_wrap_only_mode      = 2'b10,
    revolution_index_and_wrap_mode = 2'b11
  } rev_mode_e;

  // Index edge selection
  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_e;

endpackage

// *** rtl/phase_decoder.sv ***
// Quadrature phase decoder giving count pulses and direction
`timescale 1ns/10ps
module phase_decoder
  import quadrature_pos_rev_counter_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       phase_a,     // Phase A after swap
  input  wire logic       phase_b,     // Phase B after swap
  input  wire logic       enable,      // Counting allowed
  output logic            count_up,    // One-cycle up step
  output logic            count_down   // One-cycle down step
);

  logic [1:0] prev_r; // Phase pair of last cycle

  // ****************************************************************
  // Previous phase state
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 2'h0;
    end else begin
      prev_r <= {phase_a, phase_b};
    end
  end

  // direction from phases
  // Gray step forward is up, backward is down; double steps are dropped as noise
  always_comb begin
    count_up   = 1'b0;
    count_down = 1'b0;
    if (enable) begin
      case ({prev_r, phase_a, phase_b})
        4'b0010, 4'b1011, 4'b1101, 4'b0100: count_up   = 1'b1;
        4'b0001, 4'b0111, 4'b1110, 4'b1000: count_down = 1'b1;
        default: begin
          count_up   = 1'b0;
          count_down = 1'b0;
        end
      endcase
    end
  end

endmodule

// *** rtl/quadrature_position_wrap_reset_mask.sv ***
// Position counter with wrap, revolution stepping and index reset mask
`timescale 1ns/10ps
module quadrature_position_wrap_reset_mask
  import quadrature_pos_rev_counter_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        phase_a_input,
  input  wire logic        phase_b_input,
  input  wire logic        index_pulse_input,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import quadrature_pos_rev_counter_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [15:0] pos_r;        // position_count_value
  logic [15:0] rev_r;        // revolution_count_value
  logic [15:0] max_r;        // max_position_reload
  logic [11:0] ctrl_r;       // Control bits
  logic        ofl_r;        // overflow_flag
  logic        ufl_r;        // underflow_flag
  logic [1:0]  mask_r;       // Mask counter
  logic        dir_r;        // Last direction, 1 = down
  logic        idx_r;        // Index pin last cycle
  logic [3:0]  mode_prev_r;  // Modes last cycle
  logic [7:0]  awaddr_r;     // Captured write address
  logic        aw_have_r;
  logic [31:0] wdata_r;      // Captured write data
  logic [3:0]  wstrb_r;
  logic        w_have_r;

  // ****************************************************************
  // Control decode
  // ****************************************************************
  logic [1:0] pcm;
  rev_mode_e  revolution_mode_sel;
  logic       stop, gate_sel, swap;
  edge_sel_e  index_edge_sel;
  logic [1:0] reset_mask_setting;
  assign pcm      = ctrl_r[PCM_LSB +: 2];
  assign revolution_mode_sel      = rev_mode_e'(ctrl_r[RCM_LSB +: 2]);
  assign stop     = ctrl_r[POSITION_STOP_BIT_BIT];
  assign gate_sel = ctrl_r[INDEX_FUNCTION_SEL_BIT];
  assign swap     = ctrl_r[SWAP_BIT];
  assign index_edge_sel      = edge_sel_e'(ctrl_r[CGE_LSB +: 2]);
  assign reset_mask_setting     = ctrl_r[RESET_MASK_SETTING_LSB +: 2];

  // ****************************************************************
  // Phase decode
  // ****************************************************************
  logic cnt_up, cnt_dn, gate_ok;
  // level gating when select is 1
  assign gate_ok = !gate_sel || (index_edge_sel == EDGE_NONE) ||
                   (index_edge_sel == EDGE_RISE && index_pulse_input) ||
                   (index_edge_sel == EDGE_FALL && !index_pulse_input) || (index_edge_sel == EDGE_BOTH);

  phase_decoder u_dec (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .phase_a    (swap ? phase_b_input : phase_a_input),
    .phase_b    (swap ? phase_a_input : phase_b_input),
    .enable     (!stop && (pcm != 2'h0) && gate_ok),
    .count_up   (cnt_up),
    .count_down (cnt_dn)
  );

  // ****************************************************************
  // Event qualification
  // ****************************************************************
  logic idx_edge, idx_clr, stepping, reversal, ovf, unf;
  logic mask_mode, masked, mode_chg, release_mask;
  // index edges clear only in clear function
  assign idx_edge = !gate_sel &&
                    (((index_edge_sel == EDGE_RISE || index_edge_sel == EDGE_BOTH) && index_pulse_input && !idx_r) ||
                     ((index_edge_sel == EDGE_FALL || index_edge_sel == EDGE_BOTH) && !index_pulse_input && idx_r));
  assign stepping = cnt_up || cnt_dn;
  assign reversal = stepping && (cnt_dn != dir_r);
  // overflow at max while counting up
  assign ovf = cnt_up && (pos_r == max_r);
  // Underflow below zero while counting down
  assign unf = cnt_dn && (pos_r == POS_RST);
  // mask active only in modes 00 and 11
  assign mask_mode = (revolution_mode_sel == revolution_disabled_mode) ||
                     (revolution_mode_sel == revolution_index_and_wrap_mode);
  assign mode_chg  = (mode_prev_r != ctrl_r[PCM_LSB +: 4]);
  // mode or direction change releases mask
  assign release_mask = mode_chg || reversal;
  // nonzero counter suppresses index resets and revolution steps
  assign masked  = mask_mode && (mask_r != MASK_OFF) && !release_mask;
  assign idx_clr = idx_edge && (revolution_mode_sel != revolution_wrap_only_mode) && !masked;

  // ****************************************************************
  // Mask counter
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= MASK_OFF;
    end else if (!mask_mode || release_mask) begin
      mask_r <= MASK_OFF;
    end else if (idx_edge || ovf || unf) begin
      // load from setting; setting 00 loads zero
      // setting 10 loads two, so the next two counts are masked
      mask_r <= reset_mask_setting;
    end else if (stepping && mask_r != MASK_OFF) begin
      mask_r <= mask_r - 2'h1;
    end
  end

  // ****************************************************************
  // Direction, index and mode history
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_r       <= 1'b0;
      idx_r       <= 1'b0;
      mode_prev_r <= 4'h0;
    end else begin
      idx_r       <= index_pulse_input;
      mode_prev_r <= ctrl_r[PCM_LSB +: 4];
      if (stepping) begin
        dir_r <= cnt_dn;
      end
    end
  end

  // ****************************************************************
  // AXI write path
  // ****************************************************************
  logic wr_fire, pos_wr, rev_wr;
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
  assign wr_fire       = aw_have_r && w_have_r && !s_axi_bvalid;
  assign pos_wr = wr_fire && (awaddr_r == POS_OFS) && stop && (&wstrb_r[1:0]);
  assign rev_wr = wr_fire && (awaddr_r == REV_OFS) &&
                  (revolution_mode_sel == revolution_disabled_mode) && (&wstrb_r[1:0]);

  // Capture address and data independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_r > FLAG_OFS || awaddr_r[1:0] != 2'h0) ? AXI_SLVERR : AXI_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers; byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      max_r  <= MAX_RST;
      ctrl_r <= CTRL_RST;
    end else if (wr_fire) begin
      if (awaddr_r == MAX_OFS) begin
        if (wstrb_r[0]) max_r[7:0]  <= wdata_r[7:0];
        if (wstrb_r[1]) max_r[15:8] <= wdata_r[15:8];
      end
      if (awaddr_r == CTRL_OFS) begin
        if (wstrb_r[0]) ctrl_r[7:0]  <= wdata_r[7:0];
        if (wstrb_r[1]) ctrl_r[11:8] <= wdata_r[11:8];
      end
    end
  end

  // ****************************************************************
  // Position counter
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_r <= POS_RST;
    end else if (pos_wr) begin
      pos_r <= wdata_r[15:0];
    end else if (unf) begin
      pos_r <= max_r;
    end else if (ovf && revolution_mode_sel != revolution_index_only_mode) begin
      pos_r <= POS_RST;
    end else if (idx_clr) begin
      pos_r <= POS_RST;
    end else if (cnt_up) begin
      // mode 01 keeps counting through max
      pos_r <= pos_r + 16'h1;
    end else if (cnt_dn) begin
      pos_r <= pos_r - 16'h1;
    end
  end

  // ****************************************************************
  // Revolution counter
  // ****************************************************************
  logic wrap_rev, idx_rev;
  assign wrap_rev = (revolution_mode_sel == revolution_wrap_only_mode) ||
                    (revolution_mode_sel == revolution_index_and_wrap_mode);
  assign idx_rev  = idx_edge && !masked && ((revolution_mode_sel == revolution_index_only_mode) ||
                    (revolution_mode_sel == revolution_index_and_wrap_mode));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rev_r <= REV_RST;
    end else if (rev_wr) begin
      rev_r <= wdata_r[15:0];
    end else if (wrap_rev && ovf && !masked) begin
      rev_r <= rev_r + 16'h1;
    end else if (wrap_rev && unf && !masked) begin
      // step down, 0 wraps to all ones
      rev_r <= rev_r - 16'h1;
    end else if (idx_rev) begin
      // Index steps by the direction of this or last count
      rev_r <= (stepping ? cnt_dn : dir_r) ? rev_r - 16'h1 : rev_r + 16'h1;
    end
  end

  // ****************************************************************
  // Flags; set wins over a same-cycle software clear
  // ****************************************************************
  logic flag_wr;
  assign flag_wr = wr_fire && (awaddr_r == FLAG_OFS) && wstrb_r[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ofl_r <= 1'b0;
      ufl_r <= 1'b0;
    end else begin
      // overflow sets flag in every mode
      if (ovf) begin
        ofl_r <= 1'b1;
      end else if (flag_wr && !wdata_r[OVERFLOW_FLAG_BIT]) begin
        ofl_r <= 1'b0;
      end
      if (unf) begin
        ufl_r <= 1'b1;
      end else if (flag_wr && !wdata_r[UNDERFLOW_FLAG_BIT]) begin
        ufl_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI read path
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= AXI_OKAY;
      case (s_axi_araddr)
        POS_OFS:  s_axi_rdata <= {16'h0, pos_r};
        REV_OFS:  s_axi_rdata <= {16'h0, rev_r};
        MAX_OFS:  s_axi_rdata <= {16'h0, max_r};
        CTRL_OFS: s_axi_rdata <= {20'h0, ctrl_r};
        FLAG_OFS: s_axi_rdata <= {29'h0, dir_r, ufl_r, ofl_r};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  underflow_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
    unf && !pos_wr |=> pos_r == $past(max_r) && ufl_r) else $error("underflow reload");
  overflow_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ovf |=> ofl_r) else $error("overflow flag missing");
  mode1_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ovf && revolution_mode_sel == revolution_index_only_mode && !pos_wr && !idx_clr |=>
    pos_r == $past(pos_r) + 16'h1)
    else $error("mode 01 did not count through");
  mode2_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ovf && revolution_mode_sel == revolution_wrap_only_mode && !rev_wr |=> pos_r == POS_RST &&
    rev_r == $past(rev_r) + 16'h1) else $error("mode 10 wrap wrong");
  reversal_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    reversal |=> mask_r == MASK_OFF) else $error("reversal kept mask");
  mask_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mask_mode && !release_mask && (idx_edge || ovf) |=> mask_r == $past(reset_mask_setting))
    else $error("mask not loaded");
  masked_rev_a: assert property (@(posedge aclk) disable iff (!aresetn)
    masked && !rev_wr |=> rev_r == $past(rev_r)) else $error("masked step");
  write_stopped_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && awaddr_r == POS_OFS && !stop && !stepping && !idx_clr |=> $stable(pos_r))
    else $error("write while counting");
  mask_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !mask_mode |=> mask_r == MASK_OFF) else $error("mask outside modes");

endmodule

// *** dv/quad_encoder_model.sv ***
// Incremental quadrature encoder with index pulse, stepped by the bench
`timescale 1ns/10ps
module quad_encoder_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic step_en,    // One quarter step this cycle
  input  wire logic step_dn,    // Step direction, high is down
  input  wire logic index_req,  // Wanted index level
  output logic      phase_a,
  output logic      phase_b,
  output logic      index_pulse
);
  // ****
  // Gray state
  // ****
  logic [1:0] st_r;  // Quarter position within one cycle

  // One Gray step per request, phase A leads B going up; a real
  // encoder holds its levels between steps, so the phases do too
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r        <= 2'h0;
      index_pulse <= 1'b0;
    end else begin
      index_pulse <= index_req;
      if (step_en) begin
        st_r <= step_dn ? st_r - 2'h1 : st_r + 2'h1;
      end
    end
  end

  assign phase_a = st_r[1] ^ st_r[0];
  assign phase_b = st_r[1];
endmodule

// *** dv/tb_quadrature_position_wrap_reset_mask.sv ***
// Self-checking bench for the position counter with wrap and reset mask
`timescale 1ns/10ps
module tb_quadrature_position_wrap_reset_mask;
  import quadrature_pos_rev_counter_pkg::*;
  // ****
  // Signals and expected state
  // ****
  logic        aclk, aresetn, st_en, st_dn, idx_req, pha, phb, idx;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, seed;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          fail_count, checks_done, cyc;
  logic [15:0] pos, rv, mx;               // Expected counters
  logic [1:0]  pcm, rm, es, reset_mask_setting, mk;     // Expected settings and mask
  logic        stp, fs, ovf, unf, ldir, ldv; // Expected flags, direction

  quad_encoder_model i_quad_encoder_model (.aclk(aclk), .aresetn(aresetn), .step_en(st_en),
    .step_dn(st_dn), .index_req(idx_req), .phase_a(pha), .phase_b(phb), .index_pulse(idx));
  quadrature_position_wrap_reset_mask i_quadrature_position_wrap_reset_mask (.aclk(aclk),
    .aresetn(aresetn), .phase_a_input(pha), .phase_b_input(phb), .index_pulse_input(idx),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ****
  // Clock, hang guard, helpers
  // ****
  always #4 aclk = ~aclk;
  // Limit far above the few thousand cycles the run needs
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      summarize();
    end
  end

  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Full-word writes only, never single bytes
  task automatic wr(logic [7:0] a, logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk("write resp", {30'h0, bresp}, {30'h0, AXI_OKAY});
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // A position or revolution mode change drops any running mask
  task automatic cfg(logic [1:0] p, logic [1:0] r, logic s, logic f, logic [1:0] e,
                     logic [1:0] k);
    if (p != pcm || r != rm) mk = 2'h0;
    {pcm, rm, stp, fs, es, reset_mask_setting} = {p, r, s, f, e, k};
    wr(CTRL_OFS, {20'h0, k, e, 2'b00, f, s, r, p});
  endtask

  // Index edges off before a preset so it survives
  task automatic preset(logic [15:0] v);
    cfg(pcm, rm, 1'b1, fs, 2'h0, reset_mask_setting);
    wr(POS_OFS, {16'h0, v});
    pos = v;
  endtask

  // Revolution step on a wrap, held back while the mask runs
  task automatic wrap(logic dn, logic msk);
    if (rm == 2'h2 || (rm == 2'h3 && !msk)) rv = dn ? rv - 16'h1 : rv + 16'h1;
  endtask

  // Expected effect of one count
  task automatic m_count(logic dn);
    logic rvs, msk, w;
    rvs = ldv && dn != ldir;
    msk = (mk != 2'h0) && !rvs;
    w = 1'b0;
    ldir = dn;
    ldv = 1'b1;
    if (!dn && pos == mx) ovf = 1'b1;
    if (!dn && pos == mx && rm != 2'h1) begin
      pos = 16'h0;
      w = 1'b1;
      wrap(1'b0, msk);
    end else if (!dn) begin
      pos = pos + 16'h1;
    end else if (pos == 16'h0) begin
      unf = 1'b1;
      pos = mx;
      w = 1'b1;
      wrap(1'b1, msk);
    end else begin
      pos = pos - 16'h1;
    end
    // Reversal wins over a reload; the mask counts only in modes 00 and 11
    if (rvs || rm[0] != rm[1]) mk = 2'h0;
    else if (w) mk = reset_mask_setting;
    else if (mk != 2'h0) mk = mk - 2'h1;
  endtask

  // Expected effect of one index event
  task automatic m_index();
    if (fs || es == 2'h0 || rm == 2'h2) return;
    // A masked index is ignored but still reloads the mask counter
    if (mk != 2'h0) begin
      mk = reset_mask_setting;
      return;
    end
    pos = 16'h0;
    if (rm[0] && ldv) rv = ldir ? rv - 16'h1 : rv + 16'h1;
    if (rm != 2'h1) mk = reset_mask_setting;
  endtask

  // Steps with a random pause, so the encoder runs fast and slow
  task automatic step(logic dn, int n);
    repeat (n) begin
      st_en <= 1'b1;
      st_dn <= dn;
      @(posedge aclk);
      st_en <= 1'b0;
      repeat (3 + lfsr() % 4) @(posedge aclk);
      // Gate by index level when selected
      if (!stp && (!fs || es == 2'h0 || es == 2'h3 || (es == 2'h1) == idx_req)) m_count(dn);
    end
  endtask

  task automatic pulse();
    idx_req <= 1'b1;
    repeat (3) @(posedge aclk);
    idx_req <= 1'b0;
    repeat (4) @(posedge aclk);
    m_index();
    if (es == 2'h3) m_index();
  endtask

  task automatic check_state();
    logic [31:0] d;
    logic [1:0]  r;
    rd(POS_OFS, d, r);
    chk("position", d, {16'h0, pos});
    rd(REV_OFS, d, r);
    chk("revolution", d, {16'h0, rv});
    rd(FLAG_OFS, d, r);
    chk("flags", d, {29'h0, ldir, unf, ovf});
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          i;
    {aclk, aresetn, st_en, st_dn, idx_req, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {fail_count, checks_done, cyc} = '0;
    seed = 32'hbc6710c1;
    {pos, rv, pcm, rm, fs, es, reset_mask_setting, mk, ovf, unf, ldir, ldv} = '0;
    mx = 16'hffff;
    stp = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values and an unmapped read
    rd(CTRL_OFS, d, r);
    chk("ctrl reset", d, {20'h0, CTRL_RST});
    rd(MAX_OFS, d, r);
    chk("max reset", d, {16'h0, MAX_RST});
    check_state();
    rd(8'h20, d, r);
    chk("unmapped resp", {30'h0, r}, {30'h0, AXI_SLVERR});
    chk("unmapped data", d, 32'h0);
    // Write while counting is ignored, then a stopped write of zero
    wr(MAX_OFS, 32'h9);
    mx = 16'h9;
    cfg(2'h2, 2'h0, 1'b0, 1'b0, 2'h1, 2'h0);
    wr(POS_OFS, 32'h5);
    step(1'b0, 2);
    check_state();
    preset(16'h0);
    check_state();
    // Every revolution mode with up and down runs and an index pulse; all but mode 01 wrap both ways
    for (i = 0; i < 4; i++) begin
      preset(16'h7);
      cfg(2'h2, i[1:0], 1'b0, 1'b0, 2'h1, 2'h2);
      wr(FLAG_OFS, 32'h0);
      {ovf, unf} = 2'b00;
      step(1'b0, 5);
      check_state();
      step(1'b1, 3 + lfsr() % 12);
      check_state();
      pulse();
      check_state();
    end
    // Masked underflow keeps revolution, masked index is ignored
    preset(16'h2);
    cfg(2'h2, 2'h3, 1'b0, 1'b0, 2'h1, 2'h2);
    step(1'b1, 2);
    pulse();
    step(1'b1, 1);
    pulse();
    check_state();
    step(1'b1, 1);
    pulse();
    check_state();
    // Every mask setting after an overflow
    for (i = 0; i < 4; i++) begin
      preset(16'h9);
      cfg(2'h2, 2'h0, 1'b0, 1'b0, 2'h1, i[1:0]);
      step(1'b0, 2);
      pulse();
      check_state();
    end
    // Position mode change releases the mask
    cfg(2'h1, 2'h0, 1'b0, 1'b0, 2'h1, 2'h3);
    pulse();
    check_state();
    // Index level gates counting
    cfg(2'h2, 2'h0, 1'b0, 1'b1, 2'h1, 2'h0);
    step(1'b0, 3);
    idx_req <= 1'b1;
    repeat (3) @(posedge aclk);
    step(1'b0, 2);
    idx_req <= 1'b0;
    check_state();
    // Random modes, maxima, presets, edges and runs
    for (i = 0; i < 8; i++) begin
      d = lfsr();
      preset({12'h0, d[24:21]});
      wr(MAX_OFS, {27'h0, 1'b1, d[20:17]});
      mx = {11'h0, 1'b1, d[20:17]};
      cfg(2'h2, d[3:2], 1'b0, 1'b0, d[1:0], 2'h0);
      step(d[4], 1 + d[9:5]);
      if (d[10]) pulse();
      step(d[11], 1 + d[16:12]);
      check_state();
    end
    summarize();
  end
endmodule
